// [include/cnis_params.svh]
// Offsets, field positions, reset values and bus answers of the event status block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef CNIS_PARAMS_SVH
`define CNIS_PARAMS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define CNIS_ADDR_W          12
`define CNIS_ADDR_STATUS     12'h030
`define CNIS_ADDR_STAT_EN    12'h034
`define CNIS_ADDR_SIG_EN     12'h038
`define CNIS_ADDR_PIN_CTRL   12'h03c

// ****************************************************************
// Status field positions
// ****************************************************************
`define CNIS_BIT_CMD_DONE    0
`define CNIS_BIT_XFER_DONE   1
`define CNIS_BIT_BLK_GAP     2
`define CNIS_BIT_DMA         3
`define CNIS_BIT_BUF_WR_RDY  4
`define CNIS_BIT_BUF_RD_RDY  5
`define CNIS_BIT_CARD_INS    6
`define CNIS_BIT_CARD_REM    7
`define CNIS_BIT_CARD_IRQ    8
`define CNIS_BIT_PIN_A       9
`define CNIS_BIT_PIN_B       10
`define CNIS_BIT_PIN_C       11
`define CNIS_BIT_RECAL       12
`define CNIS_BIT_ERR_SUM     15
`define CNIS_W1C_MASK        16'h00ff
`define CNIS_RSVD_MASK       16'h6000

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define CNIS_RST_STATUS      16'h0000
`define CNIS_RST_STAT_EN     16'h0000
`define CNIS_RST_SIG_EN      16'h0000
`define CNIS_RST_PIN_CTRL    3'h0
`define CNIS_PIN_IDLE        4'hf
`define CNIS_RESP_OKAY       2'h0
`define CNIS_RESP_SLVERR     2'h2

`endif

// [include/cnis_pkg.sv]
// State types of the event status block and its pin filter.
// Assumes cnis_params.svh is on the include path.
`include "cnis_params.svh"

package cnis_pkg;

  // Four filtered pins: card interrupt line and shared pins A, B and C.
  typedef struct packed {
    logic [3:0] ff1;
    logic [3:0] ff2;
    logic [3:0] ff3;
    logic [3:0] stable;
  } cnis_sync_st_t;

  typedef struct packed {
    logic                    aw_have;
    logic [`CNIS_ADDR_W-1:0] aw_addr;
    logic                    w_have;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic [15:0]             status;
    logic [15:0]             stat_en;
    logic [15:0]             sig_en;
    logic [2:0]              pin_en;
    logic                    recal_prev;
    logic                    irq;
  } cnis_st_t;

endpackage : cnis_pkg

// [rtl/cnis_sync.sv]
// Three-stage filter for the active-low pins that arrive from outside the clock domain.
// Assumes pins idle high; a change is accepted once the second and third stages agree.
`timescale 1ns/10ps
`include "cnis_params.svh"

module cnis_sync (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] pin_in,
  output logic      [3:0] pin_out
);

  cnis_pkg::cnis_sync_st_t s_q;
  cnis_pkg::cnis_sync_st_t s_d;

  // The first stage feeds only the second stage; the agreement test uses stages two and three.
  always_comb begin
    s_d     = s_q;
    s_d.ff1 = pin_in;
    s_d.ff2 = s_q.ff1;
    s_d.ff3 = s_q.ff2;
    for (int i = 0; i < 4; i++) begin
      if (s_q.ff2[i] == s_q.ff3[i]) begin
        s_d.stable[i] = s_q.ff3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= {`CNIS_PIN_IDLE, `CNIS_PIN_IDLE, `CNIS_PIN_IDLE, `CNIS_PIN_IDLE};
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out = s_q.stable;

endmodule : cnis_sync

// [rtl/cnis_top.sv]
// Normal event status register with status and signal enables behind an AXI4-Lite slave.
// Assumes event pulses and levels come from logic on clk; the pins are asynchronous.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "cnis_params.svh"

// Overview of operation
// - Status enable masks read value only.
// - Interrupt when signal-enabled status bit set.
// - Write one clears clearable bits.
// - Writes ignored on cause-cleared bits.
// - One write clears several bits.
// - Card interrupt clears when card releases.
// - Bit 15 summarises error status.
// - Bit 12 sets on recalibrate request rise.
// - Running transfer may finish unrecalibrated.
// - Bit 11 follows enabled pin C low.
// - Bit 10 follows enabled pin B low; unclearable.
// - Bit 9 follows enabled pin A low.
// - Sixteen-bit status at offset 030h, fixed layout.
// - Card interrupt detected without card clock.
module cnis_top (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Event pulses from the controller, one cycle each, bits 7 down to 0.
  input  wire logic [7:0]              evt_pulse,
  input  wire logic                    err_status_any,
  input  wire logic                    sampling_recalibrate_request,
  input  wire logic                    card_irq_n,
  input  wire logic                    pin_a_n,
  input  wire logic                    pin_b_n,
  input  wire logic                    pin_c_n,
  output logic                         irq,
  input  wire logic [`CNIS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`CNIS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);

  // ****************************************************************
  // Pin filtering
  // ****************************************************************
  logic [3:0] pins_s;

  // The card line is filtered on clk, which keeps running while the card clock is stopped.
  cnis_sync u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_in  ({pin_c_n, pin_b_n, pin_a_n, card_irq_n}),
    .pin_out (pins_s)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  cnis_pkg::cnis_st_t st_q;
  cnis_pkg::cnis_st_t st_d;

  logic [15:0] wmask;
  logic [15:0] wval;
  logic [15:0] clr;
  logic [15:0] rd_val;
  logic        wr_go;
  logic        wr_hit;
  logic        rd_hit;
  logic        recal_rise;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    st_d       = st_q;
    wmask      = {{8{st_q.w_strb[1]}}, {8{st_q.w_strb[0]}}};
    wval       = st_q.w_data[15:0];
    clr        = 16'h0000;
    rd_val     = 16'h0000;
    wr_hit     = 1'b0;
    rd_hit     = 1'b0;
    recal_rise = 1'b0;

    // Write address and data are taken independently, in either order.
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_have = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    wr_go = st_q.aw_have && st_q.w_have && !st_q.bvalid;

    if (wr_go) begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      unique case (st_q.aw_addr)
        `CNIS_ADDR_STATUS: begin
          wr_hit = 1'b1;
          // Only the clearable bits take a clear; all ones may go in one access.
          clr    = wval & wmask & `CNIS_W1C_MASK;
        end
        `CNIS_ADDR_STAT_EN: begin
          wr_hit       = 1'b1;
          st_d.stat_en = ((st_q.stat_en & ~wmask) | (wval & wmask)) & ~`CNIS_RSVD_MASK;
        end
        `CNIS_ADDR_SIG_EN: begin
          wr_hit      = 1'b1;
          st_d.sig_en = ((st_q.sig_en & ~wmask) | (wval & wmask)) & ~`CNIS_RSVD_MASK;
        end
        `CNIS_ADDR_PIN_CTRL: begin
          wr_hit = 1'b1;
          if (st_q.w_strb[0]) begin
            st_d.pin_en = st_q.w_data[2:0];
          end
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
      st_d.bresp = wr_hit ? `CNIS_RESP_OKAY : `CNIS_RESP_SLVERR;
    end else if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // A new address or data beat is accepted only when its holding slot is free.
    st_d.awready = !st_d.aw_have && !st_d.bvalid;
    st_d.wready  = !st_d.w_have && !st_d.bvalid;

    // ****************************************************************
    // Status bits
    // ****************************************************************
    // A pulse in the cycle of a clear keeps its bit set, so no event is lost.
    for (int i = 0; i < 8; i++) begin
      st_d.status[i] = (st_q.status[i] & ~clr[i]) | evt_pulse[i];
    end
    // Level bits follow their cause; the write above never touches them.
    st_d.status[`CNIS_BIT_CARD_IRQ] = ~pins_s[0];
    st_d.status[`CNIS_BIT_PIN_A]    = st_q.pin_en[0] & ~pins_s[1];
    st_d.status[`CNIS_BIT_PIN_B]    = st_q.pin_en[1] & ~pins_s[2];
    st_d.status[`CNIS_BIT_PIN_C]    = st_q.pin_en[2] & ~pins_s[3];
    // The request rising sets the event; it drops only when the request is withdrawn.
    // Nothing here stalls a running transfer, which may complete before recalibration.
    recal_rise      = sampling_recalibrate_request & ~st_q.recal_prev;
    st_d.recal_prev = sampling_recalibrate_request;
    st_d.status[`CNIS_BIT_RECAL] = sampling_recalibrate_request
                                   & (st_q.status[`CNIS_BIT_RECAL] | recal_rise);
    st_d.status[14:13]             = 2'b00;
    st_d.status[`CNIS_BIT_ERR_SUM] = err_status_any;

    // The signal enable alone decides which set bits reach the host line.
    st_d.irq = |(st_d.status & st_d.sig_en);

    // ****************************************************************
    // Read channel
    // ****************************************************************
    if (s_axi_arvalid && st_q.arready) begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
        `CNIS_ADDR_STATUS:   rd_val = st_q.status & st_q.stat_en;
        `CNIS_ADDR_STAT_EN:  rd_val = st_q.stat_en;
        `CNIS_ADDR_SIG_EN:   rd_val = st_q.sig_en;
        `CNIS_ADDR_PIN_CTRL: rd_val = {13'h0, st_q.pin_en};
        default: begin
          rd_hit = 1'b0;
          rd_val = 16'h0000;
        end
      endcase
      st_d.rdata   = {16'h0000, rd_val};
      st_d.rresp   = rd_hit ? `CNIS_RESP_OKAY : `CNIS_RESP_SLVERR;
      st_d.rvalid  = 1'b1;
      st_d.arready = 1'b0;
    end else if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid  = 1'b0;
      st_d.arready = 1'b1;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q            <= '0;
      st_q.awready    <= 1'b1;
      st_q.wready     <= 1'b1;
      st_q.arready    <= 1'b1;
      st_q.status     <= `CNIS_RST_STATUS;
      st_q.stat_en    <= `CNIS_RST_STAT_EN;
      st_q.sig_en     <= `CNIS_RST_SIG_EN;
      st_q.pin_en     <= `CNIS_RST_PIN_CTRL;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign irq           = st_q.irq;
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready  = st_q.wready;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;

endmodule : cnis_top

// [testbench/cnis_monitor.sv]
// Checker for the event status block: bus answer timing and read data shape.
// Assumes it is bound to cnis_top and sees only that module's ports.
`timescale 1ns/10ps
`include "cnis_params.svh"

module cnis_monitor (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    irq,
  input wire logic [`CNIS_ADDR_W-1:0] s_axi_araddr,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic [1:0]              s_axi_rresp,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_WR_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer missing");
  AST_RSVD: assert property (s_axi_rvalid |-> s_axi_rdata[14:13] == 2'h0)
    else $error("reserved bits not zero");
  AST_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  AST_UNMAP: assert property (s_axi_arvalid && s_axi_arready && !(s_axi_araddr inside
    {12'h030, 12'h034, 12'h038, 12'h03c}) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_WR_ONE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read channel not freed");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write channel not freed");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(irq));
endmodule : cnis_monitor

// [testbench/tb_top.sv]
// Self-checking bench for the event status block, driving its AXI4-Lite slave.
// Assumes cnis_top and cnis_monitor are compiled first.
`timescale 1ns/10ps
`include "cnis_params.svh"

module tb_top;
  // ****************************************************************
  // Stimulus, bus tasks and scenarios
  // ****************************************************************
  logic        clk = 1'b0, rst_n = 1'b0, err = 1'b0, recal = 1'b0, irq;
  logic [7:0]  evt = 8'h00;
  logic [3:0]  pin_n = 4'hf;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] d;
  int          mismatches = 0, checks_done = 0;

  always #10 clk = ~clk;

  cnis_top u_dut (.clk(clk), .rst_n(rst_n), .evt_pulse(evt), .err_status_any(err),
    .sampling_recalibrate_request(recal), .card_irq_n(pin_n[0]), .pin_a_n(pin_n[1]),
    .pin_b_n(pin_n[2]), .pin_c_n(pin_n[3]), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Both beats are offered together; each is dropped once taken, as the slave may split them.
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    bit done;
    n = 0;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 50) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) begin
      mismatches++;
      summarize();
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    bit done;
    n = 0;
    done = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 50) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) begin
      mismatches++;
      summarize();
    end
  endtask : rd

  task automatic wr_ok(input logic [11:0] a, input logic [15:0] v);
    wr(a, {16'h0, v}, r);
    chk(32'(r), 32'(`CNIS_RESP_OKAY));
  endtask : wr_ok

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
    rd(a, d, r);
    chk(d, {16'h0, exp});
    chk(32'(r), 32'(`CNIS_RESP_OKAY));
  endtask : rd_chk

  task automatic t_reset();
    rd_chk(12'h030, 16'h0000);
    rd_chk(12'h034, 16'h0000);
    rd_chk(12'h038, 16'h0000);
    rd_chk(12'h03c, 16'h0000);
    chk(32'(irq), 32'h0);
  endtask : t_reset

  task automatic t_events();
    wr_ok(12'h034, 16'hffff);
    rd_chk(12'h034, 16'h9fff);
    @(posedge clk);
    evt <= 8'hff;
    @(posedge clk);
    evt <= 8'h00;
    rd_chk(12'h030, 16'h00ff);
    chk(32'(irq), 32'h0);
    wr_ok(12'h030, 16'h0005);
    rd_chk(12'h030, 16'h00fa);
    wr_ok(12'h030, 16'h0000);
    rd_chk(12'h030, 16'h00fa);
    wr_ok(12'h034, 16'h000f);
    rd_chk(12'h030, 16'h000a);
    wr_ok(12'h034, 16'hffff);
    wr_ok(12'h038, 16'h0002);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    rd_chk(12'h030, 16'h00fa);
    wr_ok(12'h030, 16'h00fa);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    wr_ok(12'h038, 16'hffff);
  endtask : t_events

  task automatic t_levels();
    err <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1);
    rd_chk(12'h030, 16'h8000);
    wr_ok(12'h030, 16'h8000);
    rd_chk(12'h030, 16'h8000);
    err <= 1'b0;
    recal <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(12'h030, 16'h1000);
    wr_ok(12'h030, 16'h1000);
    rd_chk(12'h030, 16'h1000);
    recal <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(12'h030, 16'h0000);
  endtask : t_levels

  // Pin waits cover the three filter stages plus the status flop.
  task automatic t_pins();
    pin_n[1] <= 1'b0;
    repeat (6) @(posedge clk);
    rd_chk(12'h030, 16'h0000);
    pin_n[1] <= 1'b1;
    repeat (6) @(posedge clk);
    wr_ok(12'h03c, 16'h0007);
    for (int i = 0; i < 4; i++) begin
      pin_n[i] <= 1'b0;
      repeat (6) @(posedge clk);
      rd_chk(12'h030, 16'h0100 << i);
      wr_ok(12'h030, 16'h0100 << i);
      rd_chk(12'h030, 16'h0100 << i);
      pin_n[i] <= 1'b1;
      repeat (6) @(posedge clk);
      rd_chk(12'h030, 16'h0000);
    end
  endtask : t_pins

  task automatic t_unmapped();
    rd(12'h040, d, r);
    chk(32'(r), 32'(`CNIS_RESP_SLVERR));
    chk(d, 32'h0);
    wr(12'h040, 32'hffff, r);
    chk(32'(r), 32'(`CNIS_RESP_SLVERR));
  endtask : t_unmapped

  // Byte lanes: a write only reaches the fields whose strobe is set.
  task automatic t_strobes();
    wstrb <= 4'h1;
    wr_ok(`CNIS_ADDR_STAT_EN, 16'h0000);
    rd_chk(`CNIS_ADDR_STAT_EN, 16'h9f00);
    wstrb <= 4'h2;
    wr_ok(`CNIS_ADDR_PIN_CTRL, 16'h0000);
    rd_chk(`CNIS_ADDR_PIN_CTRL, 16'h0007);
    wr_ok(`CNIS_ADDR_STAT_EN, 16'h00ff);
    rd_chk(`CNIS_ADDR_STAT_EN, 16'h0000);
    wstrb <= 4'hf;
  endtask : t_strobes

  // A reset in mid-run must drop the host line and clear every register.
  task automatic t_midreset();
    @(posedge clk);
    evt <= 8'h01;
    @(posedge clk);
    evt <= 8'h00;
    @(posedge clk);
    chk(32'(irq), 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    rst_n <= 1'b1;
    t_reset();
    wr_ok(`CNIS_ADDR_STAT_EN, 16'hffff);
    rd_chk(`CNIS_ADDR_STATUS, 16'h0000);
  endtask : t_midreset

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_events();
    t_levels();
    t_pins();
    t_unmapped();
    t_strobes();
    t_midreset();
    summarize();
  end
endmodule : tb_top

bind cnis_top cnis_monitor u_mon (.clk(clk), .rst_n(rst_n), .irq(irq),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready));
